/* rtl/cmix_qmc_pkg.sv */
`default_nettype none
package cmix_qmc_pkg;
  // ==========================================================
  // register map (byte offsets on the axi4-lite bus)
  localparam logic [7:0] mix_ctrl_off    = 8'h00; // coarse select, gain half
  localparam logic [7:0] qmc_gain_off    = 8'h04; // correction gain
  localparam logic [7:0] qmc_phase_off   = 8'h08; // phase cross term
  localparam logic [7:0] i_offset_off    = 8'h0c; // i dc offset
  localparam logic [7:0] q_offset_off    = 8'h10; // q dc offset
  localparam logic [7:0] grp_delay_off   = 8'h14; // i/q group delay
  localparam logic [7:0] status_off      = 8'h18; // phase, saturation
  // ==========================================================
  // field positions and widths
  localparam int cmix_lsb       = 0;  // coarse select field [3:0]
  localparam int mixer_gain_bit = 4;  // 1 = full scale, 0 = halve
  localparam int sync_bit       = 8;  // write 1 restarts sequence
  localparam int gd_q_lsb       = 8;  // q delay in [15:8]
  localparam int gain_frac_bits = 10; // binary point below bit 10
  localparam int phase_frac_bits = 12; // phase weight 2^-12 per lsb
  // ==========================================================
  // reset values
  localparam logic [3:0]  cmix_rst       = 4'h0;
  localparam logic        mixer_gain_rst = 1'b0;
  localparam logic [10:0] qmc_gain_rst   = 11'h400; // 1.0000
  localparam logic [11:0] qmc_phase_rst  = 12'h000;
  localparam logic [12:0] offset_rst     = 13'h0000;
  localparam logic [7:0]  grp_delay_rst  = 8'h00;
  // eighth-rate cosine/sine magnitude 0.7071 in q1.14
  localparam logic signed [15:0] cos8 = 16'sh2d41;
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic signed [15:0] i; // in-phase sample
    logic signed [15:0] q; // quadrature sample
  } iq_t;
  typedef struct packed {
    logic       gain_full; // mixer gain bit
    logic [3:0] cmix;      // coarse select
  } mix_cfg_t;
endpackage : cmix_qmc_pkg
`default_nettype wire

/* rtl/coarse_mixer_iq_correction.sv */
// Operation
// - coarse mixer shifts by multiples of fs/8
// - fs/2, +-fs/4 by negate and swap only
// - no mixing passes samples unchanged
// - fs/2 negates every second sample pair
// - +fs/4 four-phase sign-swap sequence
// - -fs/4 four-phase sign-swap sequence
// - mixer gain unused in sign-swap modes
// - fs/8 uses multiplier, combinable with others
// - select bits: 3 fs/8, 2 +fs/4, 1 fs/2, 0 -fs/4
// - combined codes give +-3fs/8 and -fs/8
// - gain bit zero halves multiplier output
// - i/q separable only for none and fs/2
// - 11-bit unsigned correction gain, default one
// - gain binary point between bits 9, 10
// - signed phase constant times q into i
// - per-channel 13-bit signed dc offset
// - offset lsb aligned with sample lsb
// - independent 8-bit group delay per channel
//
// Chosen here: the address map and the AXI4-Lite slave port.
`default_nettype none
module coarse_mixer_iq_correction (
  input  wire logic                clk_sys,       // sample clock
  input  wire logic                resetn,        // async, active low
  input  wire logic                sync_in,       // sequence restart
  input  wire logic                in_valid,      // sample pair valid
  input  wire cmix_qmc_pkg::iq_t   in_data,       // paired i/q
  output logic                     out_valid,     // output pair valid
  output cmix_qmc_pkg::iq_t        out_data,      // corrected i/q
  output logic [7:0]               i_grp_delay,   // i delay trim
  output logic [7:0]               q_grp_delay,   // q delay trim
  output logic                     iq_separable,  // real channels kept
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  // ==========================================================
  // configuration registers
  cmix_qmc_pkg::mix_cfg_t mix_cfg_reg;         // select and gain bit
  logic [10:0]            qmc_gain_reg;        // unsigned q1.10
  logic [11:0]            qmc_phase_reg;       // signed phase term
  logic [12:0]            i_channel_dc_offset; // i offset
  logic [12:0]            q_channel_dc_offset; // q offset
  logic                   sw_sync_reg;         // one-cycle sync pulse
  logic                   sat_reg;             // sticky saturation
  logic [1:0]             phase_reg;           // sequence phase

  // ==========================================================
  // axi4-lite write channel
  logic        aw_held;      // address captured
  logic        w_held;       // data captured
  logic [7:0]  awaddr_reg;   // captured address
  logic [31:0] wdata_reg;    // captured data
  logic [3:0]  wstrb_reg;    // captured strobes
  logic        wr_go;        // both halves present
  logic        wr_hit;       // mapped write address

  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (awaddr_reg <= cmix_qmc_pkg::grp_delay_off) &&
                  (awaddr_reg[1:0] == 2'b00);

  // address and data taken in either order
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held    <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held    <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready while the slot is empty
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
    end
  end

  // write response
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cmix_qmc_pkg::resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? cmix_qmc_pkg::resp_okay
                             : cmix_qmc_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register updates, byte lane by lane
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mix_cfg_reg.cmix      <= cmix_qmc_pkg::cmix_rst;
      mix_cfg_reg.gain_full <= cmix_qmc_pkg::mixer_gain_rst;
      qmc_gain_reg          <= cmix_qmc_pkg::qmc_gain_rst;
      qmc_phase_reg         <= cmix_qmc_pkg::qmc_phase_rst;
      i_channel_dc_offset   <= cmix_qmc_pkg::offset_rst;
      q_channel_dc_offset   <= cmix_qmc_pkg::offset_rst;
      i_grp_delay           <= cmix_qmc_pkg::grp_delay_rst;
      q_grp_delay           <= cmix_qmc_pkg::grp_delay_rst;
      sw_sync_reg           <= 1'b0;
    end else begin
      sw_sync_reg <= 1'b0;
      if (wr_go && wr_hit) begin
        case (awaddr_reg)
          cmix_qmc_pkg::mix_ctrl_off: begin
            if (wstrb_reg[0]) begin
              mix_cfg_reg.cmix      <= wdata_reg[3:0];
              mix_cfg_reg.gain_full <=
                wdata_reg[cmix_qmc_pkg::mixer_gain_bit];
            end
            if (wstrb_reg[1]) begin
              sw_sync_reg <= wdata_reg[cmix_qmc_pkg::sync_bit];
            end
          end
          cmix_qmc_pkg::qmc_gain_off: begin
            if (wstrb_reg[0]) qmc_gain_reg[7:0]  <= wdata_reg[7:0];
            if (wstrb_reg[1]) qmc_gain_reg[10:8] <= wdata_reg[10:8];
          end
          cmix_qmc_pkg::qmc_phase_off: begin
            if (wstrb_reg[0]) qmc_phase_reg[7:0]  <= wdata_reg[7:0];
            if (wstrb_reg[1]) qmc_phase_reg[11:8] <= wdata_reg[11:8];
          end
          cmix_qmc_pkg::i_offset_off: begin
            if (wstrb_reg[0]) i_channel_dc_offset[7:0]  <= wdata_reg[7:0];
            if (wstrb_reg[1]) i_channel_dc_offset[12:8] <= wdata_reg[12:8];
          end
          cmix_qmc_pkg::q_offset_off: begin
            if (wstrb_reg[0]) q_channel_dc_offset[7:0]  <= wdata_reg[7:0];
            if (wstrb_reg[1]) q_channel_dc_offset[12:8] <= wdata_reg[12:8];
          end
          cmix_qmc_pkg::grp_delay_off: begin
            if (wstrb_reg[0]) i_grp_delay <= wdata_reg[7:0];
            if (wstrb_reg[1]) q_grp_delay <= wdata_reg[15:8];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  logic [31:0] rd_word;  // decoded read value
  logic        rd_hit;   // mapped read address
  logic        sat_clr;  // status read clears saturation

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      cmix_qmc_pkg::mix_ctrl_off:
        rd_word = {27'h0, mix_cfg_reg.gain_full, mix_cfg_reg.cmix};
      cmix_qmc_pkg::qmc_gain_off:  rd_word = {21'h0, qmc_gain_reg};
      cmix_qmc_pkg::qmc_phase_off: rd_word = {20'h0, qmc_phase_reg};
      cmix_qmc_pkg::i_offset_off:  rd_word = {19'h0, i_channel_dc_offset};
      cmix_qmc_pkg::q_offset_off:  rd_word = {19'h0, q_channel_dc_offset};
      cmix_qmc_pkg::grp_delay_off:
        rd_word = {16'h0, q_grp_delay, i_grp_delay};
      cmix_qmc_pkg::status_off:
        rd_word = {28'h0, iq_separable, sat_reg, phase_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  assign sat_clr = s_axi_arvalid && s_axi_arready &&
                   (s_axi_araddr == cmix_qmc_pkg::status_off);

  // read answer one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cmix_qmc_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? cmix_qmc_pkg::resp_okay
                               : cmix_qmc_pkg::resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // coarse mixer: sequence phase
  // restart keeps output sequences deterministic
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 2'd0;
    end else if (sync_in || sw_sync_reg) begin
      phase_reg <= 2'd0;
    end else if (in_valid) begin
      phase_reg <= phase_reg + 2'd1;
    end
  end

  // saturating narrowing helper
  function automatic logic signed [15:0] sat16(
    input logic signed [31:0] v);
    if (v > 32'sd32767)       sat16 = 16'sh7fff;
    else if (v < -32'sd32768) sat16 = 16'sh8000;
    else                      sat16 = v[15:0];
  endfunction : sat16

  // sign-and-swap stage, no multiplier
  logic signed [15:0] ni;  // negated i
  logic signed [15:0] nq;  // negated q
  cmix_qmc_pkg::iq_t  ss;  // sign-swap result
  logic [3:0]         cm;  // active select
  logic [1:0]         ph4; // quarter phase
  logic               half_on; // fs/2 active

  assign cm = mix_cfg_reg.cmix;
  assign ni = sat16(-32'(in_data.i));
  assign nq = sat16(-32'(in_data.q));

  // quarter-rate modes step through four phases
  always_comb begin
    ph4     = phase_reg;
    half_on = cm[1];
    ss      = in_data;
    if (cm[2]) begin
      case (ph4)
        2'd0: ss = in_data;
        2'd1: begin ss.i = nq;        ss.q = in_data.i; end
        2'd2: begin ss.i = ni;        ss.q = nq;        end
        default: begin ss.i = in_data.q; ss.q = ni;     end
      endcase
    end else if (cm[0]) begin
      case (ph4)
        2'd0: ss = in_data;
        2'd1: begin ss.i = in_data.q; ss.q = ni;        end
        2'd2: begin ss.i = ni;        ss.q = nq;        end
        default: begin ss.i = nq;     ss.q = in_data.i; end
      endcase
    end
    // fs/2 negates every second pair
    if (half_on && ph4[0]) begin
      ss.i = sat16(-32'(ss.i));
      ss.q = sat16(-32'(ss.q));
    end
  end

  // eighth-rate stage: fixed-coefficient complex multiply
  logic [2:0]         ph8_reg; // eighth-rate phase
  logic signed [15:0] c8;      // cosine term
  logic signed [15:0] s8;      // sine term
  logic signed [31:0] mi;      // multiplier i
  logic signed [31:0] mq;      // multiplier q
  cmix_qmc_pkg::iq_t  mix_reg; // mixer output
  logic               mv_reg;  // mixer output valid

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph8_reg <= 3'd0;
    end else if (sync_in || sw_sync_reg) begin
      ph8_reg <= 3'd0;
    end else if (in_valid) begin
      ph8_reg <= ph8_reg + 3'd1;
    end
  end

  // cosine/sine of 2*pi*n/8 in q1.14
  always_comb begin
    case (ph8_reg)
      3'd0: begin c8 = 16'sh4000; s8 = 16'sh0000; end
      3'd1: begin c8 = cmix_qmc_pkg::cos8;  s8 = cmix_qmc_pkg::cos8;  end
      3'd2: begin c8 = 16'sh0000; s8 = 16'sh4000; end
      3'd3: begin c8 = -cmix_qmc_pkg::cos8; s8 = cmix_qmc_pkg::cos8;  end
      3'd4: begin c8 = -16'sh4000; s8 = 16'sh0000; end
      3'd5: begin c8 = -cmix_qmc_pkg::cos8; s8 = -cmix_qmc_pkg::cos8; end
      3'd6: begin c8 = 16'sh0000; s8 = -16'sh4000; end
      default: begin c8 = cmix_qmc_pkg::cos8; s8 = -cmix_qmc_pkg::cos8; end
    endcase
    // gain_full=1 keeps scale, 0 halves (one more shift)
    mi = (ss.i * c8 - ss.q * s8) >>> (mix_cfg_reg.gain_full ? 14 : 15);
    mq = (ss.i * s8 + ss.q * c8) >>> (mix_cfg_reg.gain_full ? 14 : 15);
  end

  // multiplier only in fs/8 combos; gain bit unused otherwise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mix_reg <= '0;
      mv_reg  <= 1'b0;
    end else begin
      mv_reg <= in_valid;
      if (cm[3]) begin
        mix_reg.i <= sat16(mi);
        mix_reg.q <= sat16(mq);
      end else begin
        mix_reg <= ss;
      end
    end
  end

  // ==========================================================
  // quadrature correction: gain, phase, offset
  logic signed [31:0] gi;  // i with phase term, scaled
  logic signed [31:0] gq;  // q scaled
  logic signed [31:0] pq;  // phase cross term
  cmix_qmc_pkg::iq_t  qc_reg; // gain/phase stage
  logic               qv_reg;

  always_comb begin
    pq = (32'(mix_reg.q) * 32'(signed'(qmc_phase_reg)))
         >>> cmix_qmc_pkg::phase_frac_bits;
    gi = ((32'(mix_reg.i) + pq) * signed'(32'(qmc_gain_reg)))
         >>> cmix_qmc_pkg::gain_frac_bits;
    gq = (32'(mix_reg.q) * signed'(32'(qmc_gain_reg)))
         >>> cmix_qmc_pkg::gain_frac_bits;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      qc_reg <= '0;
      qv_reg <= 1'b0;
    end else begin
      qv_reg   <= mv_reg;
      qc_reg.i <= sat16(gi);
      qc_reg.q <= sat16(gq);
    end
  end

  // offset added lsb aligned, then clipped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid  <= qv_reg;
      out_data.i <= sat16(32'(qc_reg.i) +
                    32'(signed'(i_channel_dc_offset)));
      out_data.q <= sat16(32'(qc_reg.q) +
                    32'(signed'(q_channel_dc_offset)));
    end
  end

  // ==========================================================
  // status: sticky saturation, separability flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sat_reg      <= 1'b0;
      iq_separable <= 1'b1;
    end else begin
      iq_separable <= (cm == 4'b0000) || (cm == 4'b0010);
      if ((gi > 32'sd32767) || (gi < -32'sd32768) ||
          (gq > 32'sd32767) || (gq < -32'sd32768))
        sat_reg <= 1'b1; // set wins over clear
      else if (sat_clr)
        sat_reg <= 1'b0;
    end
  end
endmodule : coarse_mixer_iq_correction
`default_nettype wire

/* verif/cmix_qmc_chk_sva.sv */
`default_nettype none
module cmix_qmc_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        in_valid,
  input wire logic        out_valid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  // ==========================================================
  // datapath timing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_OUT_LAT: assert property (in_valid |-> ##3 out_valid)
    else $error("sample pair lost in pipeline");
  AST_OUT_IDLE: assert property (!in_valid |-> ##3 !out_valid)
    else $error("output pair without input pair");
  // ==========================================================
  // register access handshakes
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_ANS: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_CAUSE: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
    else $error("read answer without request");
  AST_W_ANS: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  // ==========================================================
  // scenario coverage
  cover property (in_valid ##3 out_valid);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == cmix_qmc_pkg::resp_slverr);
endmodule : cmix_qmc_chk
bind coarse_mixer_iq_correction cmix_qmc_chk cmix_qmc_chk_i (.*);
`default_nettype wire

/* verif/iq_src_model.sv */
`default_nettype none
module iq_src_model (
  input  wire logic               clk_sys,  // sample clock
  input  wire logic               resetn,   // async, active low
  input  wire logic               start,    // begin a burst
  input  wire logic [7:0]         count,    // pairs in burst
  input  wire logic signed [15:0] i0,       // first i value
  input  wire logic signed [15:0] q0,       // first q value
  input  wire logic signed [15:0] step,     // ramp per pair
  output logic                    in_valid, // pair valid
  output cmix_qmc_pkg::iq_t       in_data   // paired i/q
);
  // ==========================================================
  // burst counters
  logic [7:0] left_reg; // pairs still to send
  logic [7:0] k_reg;    // index in burst
  // one pair per cycle until burst is spent
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_reg <= 8'h00;
      k_reg    <= 8'h00;
    end else if (start) begin
      left_reg <= count;
      k_reg    <= 8'h00;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
      k_reg    <= k_reg + 8'h01;
    end
  end
  // ramp data; junk pattern outside bursts
  assign in_valid = (left_reg != 8'h00);
  assign in_data  = in_valid ?
    {16'(i0 + $signed({8'h00, k_reg}) * step),
     16'(q0 - $signed({8'h00, k_reg}) * step)} :
    {~k_reg, k_reg, k_reg, ~k_reg};
endmodule : iq_src_model
`default_nettype wire

/* verif/coarse_mixer_iq_correction_tb.sv */
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module coarse_mixer_iq_correction_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic clk_sys, resetn, sync_in, in_valid, out_valid, iq_separable;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, src_go;
  logic [7:0]  i_grp_delay, q_grp_delay, s_axi_awaddr, s_axi_araddr, src_n;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic signed [15:0] src_i, src_q, src_step;
  cmix_qmc_pkg::iq_t in_data, out_data;
  cmix_qmc_pkg::iq_t got_q[$]; // captured output pairs
  logic [3:0] modes[4] = '{4'h0, 4'h2, 4'h4, 4'h1};
  int num_errors, compares;
  coarse_mixer_iq_correction coarse_mixer_iq_correction_i (.*);
  iq_src_model iq_src_model_i (.clk_sys(clk_sys), .resetn(resetn),
    .start(src_go), .count(src_n), .i0(src_i), .q0(src_q), .step(src_step),
    .in_valid(in_valid), .in_data(in_data));
  // ==========================================================
  // clock, monitor, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (out_valid === 1'b1) got_q.push_back(out_data);
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        `CHK("bresp", cmix_qmc_pkg::resp_okay, s_axi_bresp)
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_d = s_axi_rdata; rd_r = s_axi_rresp; s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  // ==========================================================
  // expected sign-and-swap sequence
  function automatic cmix_qmc_pkg::iq_t seq(input logic [3:0] m, input int k,
                                            input logic signed [15:0] i, q);
    cmix_qmc_pkg::iq_t r;
    r = {i, q};
    case (m)
      4'h2: if (k % 2) r = {-i, -q};
      4'h4: case (k % 4) 1: r = {-q, i}; 2: r = {-i, -q}; 3: r = {q, -i};
        default: ; endcase
      4'h1: case (k % 4) 1: r = {q, -i}; 2: r = {-i, -q}; 3: r = {-q, i};
        default: ; endcase
      default: ;
    endcase
    return r;
  endfunction : seq
  // burst after a sync pulse, compare every output pair
  task automatic run(input logic [3:0] m, input logic [7:0] n,
    input logic signed [15:0] i0, q0, st, input logic fix,
    input logic signed [15:0] xi, xq);
    int k;
    cmix_qmc_pkg::iq_t e;
    got_q.delete();
    @(posedge clk_sys); sync_in <= 1'b1;
    @(posedge clk_sys); sync_in <= 1'b0; src_go <= 1'b1; src_n <= n;
    src_i <= i0; src_q <= q0; src_step <= st;
    @(posedge clk_sys); src_go <= 1'b0;
    repeat (16) @(posedge clk_sys);
    `CHK("pairs", int'(n), got_q.size())
    for (k = 0; k < got_q.size(); k++) begin
      e = fix ? {xi, xq} : seq(m, k, 16'(i0 + k * st), 16'(q0 - k * st));
      `CHK("iq", e, got_q[k])
    end
  endtask : run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // ==========================================================
  // main sequence
  initial begin
    {resetn, sync_in, src_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, src_n, src_i, src_q, src_step} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(cmix_qmc_pkg::qmc_gain_off);
    `CHK("gain_rst", 32'h400, rd_d)
    rd(cmix_qmc_pkg::mix_ctrl_off);
    `CHK("ctrl_rst", 32'h0, rd_d)
    foreach (modes[j]) begin
      wr(cmix_qmc_pkg::mix_ctrl_off, {28'h0, modes[j]});
      run(modes[j], 8'd8, 300, -200, 64, 1'b0, 0, 0);
      `CHK("sep", modes[j] == 4'h0 || modes[j] == 4'h2, iq_separable)
    end
    wr(cmix_qmc_pkg::mix_ctrl_off, 32'h8);
    run(4'h8, 8'd1, 1000, 0, 0, 1'b1, 500, 0);
    `CHK("sep8", 1'b0, iq_separable)
    rd(cmix_qmc_pkg::status_off);
    `CHK("status", 32'h1, rd_d)
    wr(cmix_qmc_pkg::mix_ctrl_off, 32'h108);
    rd(cmix_qmc_pkg::status_off);
    `CHK("sw_sync", 32'h0, rd_d)
    wr(cmix_qmc_pkg::qmc_gain_off, 32'h5a8);
    run(4'h8, 8'd1, 1000, 0, 0, 1'b1, 707, 0);
    wr(cmix_qmc_pkg::qmc_gain_off, 32'h400);
    wr(cmix_qmc_pkg::mix_ctrl_off, 32'h18);
    run(4'h8, 8'd1, 1000, 0, 0, 1'b1, 1000, 0);
    wr(cmix_qmc_pkg::mix_ctrl_off, 32'h0);
    wr(cmix_qmc_pkg::qmc_gain_off, 32'h200);
    run(4'h0, 8'd4, 1000, -600, 0, 1'b1, 500, -300);
    wr(cmix_qmc_pkg::qmc_gain_off, 32'h400);
    wr(cmix_qmc_pkg::qmc_phase_off, 32'h400);
    run(4'h0, 8'd4, 100, 400, 0, 1'b1, 200, 400);
    wr(cmix_qmc_pkg::qmc_phase_off, 32'h0);
    wr(cmix_qmc_pkg::i_offset_off, 32'h5);
    wr(cmix_qmc_pkg::q_offset_off, 32'h1ffd);
    run(4'h0, 8'd4, 100, 100, 0, 1'b1, 105, 97);
    wr(cmix_qmc_pkg::i_offset_off, 32'hfff);
    wr(cmix_qmc_pkg::q_offset_off, 32'h1000);
    run(4'h0, 8'd4, 32000, -30000, 0, 1'b1, 16'sh7fff, 16'sh8000);
    wr(cmix_qmc_pkg::grp_delay_off, 32'ha55a);
    repeat (3) @(posedge clk_sys);
    `CHK("gd_i", 8'h5a, i_grp_delay)
    `CHK("gd_q", 8'ha5, q_grp_delay)
    rd(cmix_qmc_pkg::grp_delay_off);
    `CHK("gd_rd", 32'ha55a, rd_d)
    rd(8'h40);
    `CHK("unmapped", cmix_qmc_pkg::resp_slverr, rd_r)
    close_out();
  end
endmodule : coarse_mixer_iq_correction_tb
`default_nettype wire
